// >>> rtl/sis_pkg.sv
// Purpose: Shared constants for the system integrity status block
// Assumes: 8-bit register port, one clock
// Notes:   Offsets are register indexes on the plain register port
package sis_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned EVT_W  = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_INTEGRITY  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'h2;

  // Integrity register fields
  localparam int unsigned BIT_RSV_LO     = 5;
  localparam int unsigned BIT_WDG_FLAG   = 4;
  localparam int unsigned BIT_PLL_LOCKED = 3;
  localparam int unsigned BIT_LVD_FLAG   = 2;
  localparam int unsigned BIT_SUPPLY     = 1;
  localparam int unsigned BIT_SUPPLY_IE  = 0;

  // Interrupt status and mask fields
  localparam int unsigned EVT_SUPPLY = 0;
  localparam int unsigned EVT_WDG    = 1;
  localparam int unsigned EVT_LVD    = 2;
  localparam int unsigned EVT_PLL    = 3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
  localparam logic [EVT_W-1:0]  RST_EVT    = 4'h0;
  localparam logic [2:0]        RSV_ZEROES = 3'h0;

endpackage : sis_pkg

// >>> rtl/sis_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs come from outside the core_clk domain
// Notes:   Output changes only when stages two and three agree
module sis_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A glitch seen by one stage only never reaches the output
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          sync_out[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule : sis_sync

// >>> rtl/sis_integrity.sv
// Purpose: System integrity status register with reset cause, lock and supply flags
// Assumes: Reset-cause pulses and isr entry come from core_clk logic; lock and
//          supply levels come from analog blocks and are synchronised here
// Notes:   Read data valid one cycle after the read strobe
//
// The strobed register port and the address map are this design's own decisions.
module sis_integrity (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic [sis_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sis_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [sis_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       wdg_reset_evt,
  input  wire logic                       lvd_reset_evt,
  input  wire logic                       lvd_enabled,
  input  wire logic                       pll_locked_in,
  input  wire logic                       supply_below_in,
  input  wire logic                       isr_enter,
  output logic                            irq
);

  function automatic logic hit(input logic [sis_pkg::ADDR_W-1:0] addr,
                               input logic [sis_pkg::ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  logic                       locked_q;
  logic                       supply_q;
  logic                       supply_prev_reg;
  logic                       wdg_flag_reg;
  logic                       lvd_flag_reg;
  logic                       supply_ie_reg;
  logic [sis_pkg::EVT_W-1:0]  irq_status_reg;
  logic [sis_pkg::EVT_W-1:0]  irq_status_next;
  logic [sis_pkg::EVT_W-1:0]  irq_mask_reg;
  logic                       locked_prev_reg;
  logic [sis_pkg::EVT_W-1:0]  evt;
  logic [sis_pkg::EVT_W-1:0]  clr;
  logic                       wr_integ;
  logic                       rd_integ;
  logic                       wr_status;
  logic                       wr_mask;
  logic                       lvd_evt_ok;
  logic                       supply_rise;
  logic [sis_pkg::DATA_W-1:0] integ_value;

  // Analog levels cross into the core clock here
  sis_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({pll_locked_in, supply_below_in}),
    .sync_out ({locked_q, supply_q})
  );

  assign wr_integ    = reg_wr && hit(reg_addr, sis_pkg::OFS_INTEGRITY);
  assign rd_integ    = reg_rd && hit(reg_addr, sis_pkg::OFS_INTEGRITY);
  assign wr_status   = reg_wr && hit(reg_addr, sis_pkg::OFS_IRQ_STATUS);
  assign wr_mask     = reg_wr && hit(reg_addr, sis_pkg::OFS_IRQ_MASK);
  assign lvd_evt_ok  = lvd_reset_evt && lvd_enabled;
  assign supply_rise = supply_q && !supply_prev_reg;

  // Reserved bits always read zero, so software writes there are dropped
  assign integ_value = {sis_pkg::RSV_ZEROES, wdg_flag_reg, locked_q,
                        lvd_flag_reg, supply_q, supply_ie_reg};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_prev_reg <= 1'b0;
      locked_prev_reg <= 1'b0;
    end else begin
      supply_prev_reg <= supply_q;
      locked_prev_reg <= locked_q;
    end
  end

  // Watchdog flag: a low-voltage reset outranks everything so the cause reads stable
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdg_flag_reg <= 1'b0;
    end else if (lvd_evt_ok) begin
      wdg_flag_reg <= 1'b0;
    end else if (wdg_reset_evt) begin
      wdg_flag_reg <= 1'b1;
    end else if (wr_integ && !reg_wdata[sis_pkg::BIT_WDG_FLAG]) begin
      wdg_flag_reg <= 1'b0;
    end
  end

  // Low-voltage flag: set wins over the read that clears it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvd_flag_reg <= 1'b0;
    end else if (lvd_evt_ok) begin
      lvd_flag_reg <= 1'b1;
    end else if (rd_integ || !lvd_enabled) begin
      lvd_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_ie_reg <= 1'b0;
    end else if (wr_integ) begin
      supply_ie_reg <= reg_wdata[sis_pkg::BIT_SUPPLY_IE];
    end
  end

  // Sticky events; a new event in the clearing cycle is kept
  always_comb begin
    evt = sis_pkg::RST_EVT;
    clr = sis_pkg::RST_EVT;
    evt[sis_pkg::EVT_SUPPLY] = supply_rise && supply_ie_reg;
    evt[sis_pkg::EVT_WDG]    = wdg_reset_evt;
    evt[sis_pkg::EVT_LVD]    = lvd_evt_ok;
    evt[sis_pkg::EVT_PLL]    = locked_q ^ locked_prev_reg;
    if (wr_status) begin
      clr = reg_wdata[sis_pkg::EVT_W-1:0];
    end
    clr[sis_pkg::EVT_SUPPLY] = clr[sis_pkg::EVT_SUPPLY] || isr_enter;
    irq_status_next = (irq_status_reg & ~clr) | evt;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_reg <= sis_pkg::RST_EVT;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= sis_pkg::RST_EVT;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[sis_pkg::EVT_W-1:0];
    end
  end

  // Registered so the output never glitches; costs one cycle of latency
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= sis_pkg::RST_BYTE;
    end else if (reg_rd) begin
      if (hit(reg_addr, sis_pkg::OFS_INTEGRITY)) begin
        reg_rdata <= integ_value;
      end else if (hit(reg_addr, sis_pkg::OFS_IRQ_STATUS)) begin
        reg_rdata <= {{(sis_pkg::DATA_W-sis_pkg::EVT_W){1'b0}}, irq_status_reg};
      end else if (hit(reg_addr, sis_pkg::OFS_IRQ_MASK)) begin
        reg_rdata <= {{(sis_pkg::DATA_W-sis_pkg::EVT_W){1'b0}}, irq_mask_reg};
      end else begin
        reg_rdata <= sis_pkg::RST_BYTE;
      end
    end else begin
      reg_rdata <= sis_pkg::RST_BYTE;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  reserved_read_zero_a: assert property (
    rd_integ |=> reg_rdata[sis_pkg::DATA_W-1:sis_pkg::BIT_RSV_LO] == sis_pkg::RSV_ZEROES
  ) else $error("reserved bits read nonzero");

  wdg_flag_set_a: assert property (
    wdg_reset_evt && !lvd_evt_ok |=> wdg_flag_reg
  ) else $error("watchdog reset did not set flag");

  wdg_flag_clear_a: assert property (
    (lvd_evt_ok || (wr_integ && !reg_wdata[sis_pkg::BIT_WDG_FLAG] && !wdg_reset_evt))
      |=> !wdg_flag_reg
  ) else $error("watchdog flag not cleared");

  lvd_cause_a: assert property (
    lvd_evt_ok ##1 rd_integ |=> reg_rdata[sis_pkg::BIT_LVD_FLAG]
                                && !reg_rdata[sis_pkg::BIT_WDG_FLAG]
  ) else $error("low-voltage cause misreported");

  pll_lock_read_a: assert property (
    rd_integ |=> reg_rdata[sis_pkg::BIT_PLL_LOCKED] == $past(locked_q)
  ) else $error("lock flag read mismatch");

  lvd_read_clear_a: assert property (
    rd_integ && !lvd_evt_ok |=> !lvd_flag_reg
  ) else $error("read did not clear low-voltage flag");

  lvd_disabled_a: assert property (
    !lvd_enabled |=> !lvd_flag_reg
  ) else $error("low-voltage flag set while detector disabled");

  supply_read_a: assert property (
    rd_integ |=> reg_rdata[sis_pkg::BIT_SUPPLY] == $past(supply_q)
  ) else $error("supply flag read mismatch");

  supply_irq_a: assert property (
    supply_rise && supply_ie_reg && irq_mask_reg[sis_pkg::EVT_SUPPLY]
      && !wr_mask |=> irq_status_reg[sis_pkg::EVT_SUPPLY] ##1 irq
  ) else $error("supply warning did not raise interrupt");

  isr_clear_a: assert property (
    isr_enter && !evt[sis_pkg::EVT_SUPPLY] |=> !irq_status_reg[sis_pkg::EVT_SUPPLY]
  ) else $error("isr entry did not clear pending supply interrupt");

  hw_flag_write_a: assert property (
    wr_integ ##1 rd_integ |=> reg_rdata[sis_pkg::BIT_PLL_LOCKED] == $past(locked_q)
                              && reg_rdata[sis_pkg::BIT_SUPPLY] == $past(supply_q)
  ) else $error("write disturbed hardware-only flag");

  irq_follow_a: assert property (
    irq == $past(|(irq_status_reg & irq_mask_reg))
  ) else $error("interrupt output does not follow status and mask");

  wdg_flag_hold_a: assert property (
    wdg_flag_reg && !lvd_evt_ok && !(wr_integ && !reg_wdata[sis_pkg::BIT_WDG_FLAG])
      |=> wdg_flag_reg
  ) else $error("watchdog flag lost without a clear");

  wdg_one_write_a: assert property (
    wr_integ && reg_wdata[sis_pkg::BIT_WDG_FLAG] && !wdg_flag_reg && !wdg_reset_evt
      |=> !wdg_flag_reg
  ) else $error("writing one set the watchdog flag");

  wdg_event_a: assert property (
    wdg_reset_evt |=> irq_status_reg[sis_pkg::EVT_WDG]
  ) else $error("watchdog reset not recorded in status");

  lvd_flag_set_a: assert property (
    lvd_evt_ok |=> lvd_flag_reg && irq_status_reg[sis_pkg::EVT_LVD]
  ) else $error("low-voltage reset not recorded");

  lvd_flag_hold_a: assert property (
    lvd_flag_reg && !rd_integ && lvd_enabled |=> lvd_flag_reg
  ) else $error("low-voltage flag lost without a read");

  lock_change_a: assert property (
    locked_q != locked_prev_reg |=> irq_status_reg[sis_pkg::EVT_PLL]
  ) else $error("lock change not recorded in status");

  supply_ie_write_a: assert property (
    wr_integ |=> supply_ie_reg == $past(reg_wdata[sis_pkg::BIT_SUPPLY_IE])
  ) else $error("interrupt enable write lost");

  supply_gated_a: assert property (
    !supply_ie_reg && !irq_status_reg[sis_pkg::EVT_SUPPLY]
      |=> !irq_status_reg[sis_pkg::EVT_SUPPLY]
  ) else $error("supply event recorded while disabled");

  status_w1c_a: assert property (
    wr_status && !evt[sis_pkg::EVT_WDG] && reg_wdata[sis_pkg::EVT_WDG]
      |=> !irq_status_reg[sis_pkg::EVT_WDG]
  ) else $error("write of one did not clear status bit");

  mask_write_a: assert property (
    wr_mask |=> irq_mask_reg == $past(reg_wdata[sis_pkg::EVT_W-1:0])
  ) else $error("mask write lost");

  idle_rdata_a: assert property (
    !reg_rd |=> reg_rdata == sis_pkg::RST_BYTE
  ) else $error("read data not zero outside a read");

  unmapped_read_a: assert property (
    reg_rd && reg_addr > sis_pkg::OFS_IRQ_MASK |=> reg_rdata == sis_pkg::RST_BYTE
  ) else $error("unmapped index read nonzero");

  status_read_a: assert property (
    reg_rd && hit(reg_addr, sis_pkg::OFS_IRQ_STATUS)
      |=> reg_rdata[sis_pkg::EVT_W-1:0] == $past(irq_status_reg)
  ) else $error("status read mismatch");

  wdg_cause_c: cover property (
    wdg_reset_evt ##1 rd_integ ##1 reg_rdata[sis_pkg::BIT_WDG_FLAG]
  );

  supply_irq_c: cover property (
    supply_rise && supply_ie_reg ##[1:3] irq
  );

  isr_clear_c: cover property (
    irq ##1 isr_enter ##2 !irq
  );

  lvd_read_c: cover property (
    lvd_evt_ok ##[1:4] rd_integ ##1 !lvd_flag_reg
  );

  lock_change_c: cover property (
    locked_q && !locked_prev_reg ##[1:20] rd_integ
  );

endmodule : sis_integrity

// >>> testbench/sis_partner.sv
// Purpose: Model of watchdog, low-voltage detector, PLL and supply monitor
// Assumes: Bench requests change just after core_clk edges
// Notes:   Lock and supply move 7 ns off the edge, like unsynchronised levels
module sis_partner (
  input  wire logic core_clk,
  input  wire logic wdg_req,
  input  wire logic lvd_req,
  input  wire logic lvd_opt,
  input  wire logic lock_req,
  input  wire logic low_req,
  output logic      wdg_reset_evt,
  output logic      lvd_reset_evt,
  output logic      lvd_enabled,
  output logic      pll_locked_in,
  output logic      supply_below_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wdg_reset_evt   = 1'b0;
    lvd_reset_evt   = 1'b0;
    lvd_enabled     = 1'b0;
    pll_locked_in   = 1'b0;
    supply_below_in = 1'b0;
  end
  always @(posedge core_clk) begin
    wdg_reset_evt <= wdg_req;            // One pulse per watchdog reset
    lvd_reset_evt <= lvd_req & lvd_opt;  // A disabled detector never fires
    lvd_enabled   <= lvd_opt;
  end
  // Levels land off the edge on purpose, so the design's synchroniser is exercised
  always @(lock_req) pll_locked_in <= #7 lock_req;
  always @(low_req) supply_below_in <= #7 low_req;
endmodule : sis_partner

// >>> testbench/sis_integrity_tb_top.sv
// Purpose: Self-checking bench for the system integrity status block
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Random mask and unmapped traffic from a fixed seed
module sis_integrity_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk, sys_rst, reg_wr, reg_rd, isr_enter, irq;
  logic       wdg_req, lvd_req, lvd_opt, lock_req, low_req;
  logic       wdg_evt, lvd_evt, lvd_en, lock_in, low_in;
  logic [3:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, rd_val, d;
  int         err_count, comparisons, cycles;
  integer     seed;
  sis_partner far (.core_clk(core_clk), .wdg_req(wdg_req), .lvd_req(lvd_req),
    .lvd_opt(lvd_opt), .lock_req(lock_req), .low_req(low_req), .wdg_reset_evt(wdg_evt),
    .lvd_reset_evt(lvd_evt), .lvd_enabled(lvd_en), .pll_locked_in(lock_in),
    .supply_below_in(low_in));
  sis_integrity uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdg_reset_evt(wdg_evt), .lvd_reset_evt(lvd_evt), .lvd_enabled(lvd_en),
    .pll_locked_in(lock_in), .supply_below_in(low_in), .isr_enter(isr_enter), .irq(irq));
  always #12.5 core_clk = ~core_clk;
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // Whole run is well under 2000 cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  function automatic logic [7:0] integ(input logic w, k, l, s, e);
    integ = 8'h00;
    integ[sis_pkg::BIT_WDG_FLAG]   = w;
    integ[sis_pkg::BIT_PLL_LOCKED] = k;
    integ[sis_pkg::BIT_LVD_FLAG]   = l;
    integ[sis_pkg::BIT_SUPPLY]     = s;
    integ[sis_pkg::BIT_SUPPLY_IE]  = e;
  endfunction : integ
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t irq got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge core_clk);
    reg_addr  <= ad;
    reg_wdata <= dt;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
    chk8(rd_val, exp);
  endtask : rchk
  task automatic fire(input logic w);
    @(posedge core_clk);
    wdg_req <= w;
    lvd_req <= ~w;
    @(posedge core_clk);
    wdg_req <= 1'b0;
    lvd_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : fire
  // Bounded wait: a stuck irq shows as a mismatch, not a hang
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 12 && irq !== exp; i++) @(posedge core_clk);
    #1 chk1(irq, exp);
  endtask : wait_irq
  initial begin
    {core_clk, reg_wr, reg_rd, isr_enter, wdg_req, lvd_req, lock_req, low_req} = 8'h00;
    {reg_addr, reg_wdata, err_count, comparisons, cycles} = '0;
    lvd_opt = 1'b1;
    seed    = 32'hA7C7;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 0, 0));
    rchk(sis_pkg::OFS_IRQ_STATUS, 8'h00);
    $display("test reset done");
    wr(sis_pkg::OFS_IRQ_MASK, 8'h02);
    fire(1'b1);
    wait_irq(1'b1);
    rchk(sis_pkg::OFS_INTEGRITY, integ(1, 0, 0, 0, 0));
    wr(sis_pkg::OFS_INTEGRITY, 8'h10);
    rchk(sis_pkg::OFS_INTEGRITY, integ(1, 0, 0, 0, 0));
    wr(sis_pkg::OFS_INTEGRITY, 8'h00);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 0, 0));
    wr(sis_pkg::OFS_IRQ_STATUS, 8'h02);
    wait_irq(1'b0);
    $display("test watchdog done");
    fire(1'b1);
    fire(1'b0);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 1, 0, 0));
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 0, 0));
    $display("test low voltage done");
    lock_req <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(sis_pkg::OFS_INTEGRITY, 8'h0B);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 1, 0, 0, 1));
    lock_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(sis_pkg::OFS_INTEGRITY, 8'h0A);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 0, 0));
    $display("test lock done");
    wr(sis_pkg::OFS_IRQ_STATUS, 8'h0F);
    wr(sis_pkg::OFS_IRQ_MASK, 8'h01);
    wr(sis_pkg::OFS_INTEGRITY, 8'h01);
    low_req <= 1'b1;
    wait_irq(1'b1);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 1, 1));
    @(posedge core_clk);
    isr_enter <= 1'b1;
    @(posedge core_clk);
    isr_enter <= 1'b0;
    wait_irq(1'b0);
    rchk(sis_pkg::OFS_IRQ_STATUS, 8'h00);
    low_req <= 1'b0;
    wr(sis_pkg::OFS_INTEGRITY, 8'h00);
    repeat (8) @(posedge core_clk);
    low_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    rchk(sis_pkg::OFS_IRQ_STATUS, 8'h00);
    rchk(sis_pkg::OFS_INTEGRITY, integ(0, 0, 0, 1, 0));
    $display("test supply done");
    lvd_opt <= 1'b0;
    wr(sis_pkg::OFS_IRQ_STATUS, 8'h0F);
    fire(1'b1);
    fire(1'b0);
    rchk(sis_pkg::OFS_IRQ_STATUS, 8'h02);
    wr(sis_pkg::OFS_IRQ_STATUS, 8'h0F);
    wr(sis_pkg::OFS_INTEGRITY, 8'h00);
    lvd_opt <= 1'b1;
    $display("test detector off done");
    for (int i = 0; i < 20; i++) begin
      d = 8'($random(seed));
      a = 4'(3 + ($random(seed) & 7));
      wr(sis_pkg::OFS_IRQ_MASK, {4'h0, d[3:0]});
      rchk(sis_pkg::OFS_IRQ_MASK, {4'h0, d[3:0]});
      wr(a, d);
      rchk(a, 8'h00);
    end
    $display("test random done");
    summarize();
  end
endmodule : sis_integrity_tb_top
